// File: src/spg_step_gen.sv
// Purpose: step pulse generator with register port and up to six pins
// Assumes: single 50 MHz clock, synchronous register strobes
// Notes:   pins are released (oe_n high) above the configured width
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ns
// Notes on behaviour
// - mode bit picks position or velocity
// - disable stops steps, velocity feedback zero
// - signed 32-bit step counter reported
// - position feedback scaled, finer than step
// - zero velocity limit means fastest achievable
// - acceleration limited; zero disables limiting
// - step pulse lasts programmed length
// - programmed gap between pulses
// - direction settles before pulse starts
// - direction held after pulse ends
// - format selects step/dir, up/down, quad, table
// - quadrature step is one full Gray cycle
// - table length from format, six pins
// - four words, one byte per phase
// - two to six pins, rest released
// - velocity feedback from measured step rate
module spg_step_gen
	import spg_pkg::*;
(
	input  wire logic                 sys_clk_in,
	input  wire logic                 rst_n_in,
	input  wire spg_req_t             req_in,
	output logic [31:0]               rdata_out,
	output logic [PIN_MAX-1:0]        pin_out,
	output logic [PIN_MAX-1:0]        pin_oe_n_out
);
	// ns to cycles, rounded up, never below one
	function automatic logic [31:0] ns2cyc(input logic [31:0] ns);
		logic [31:0] c;
		c = 32'((33'(ns) + 33'(CLK_PERIOD_NS - 1)) / 33'(CLK_PERIOD_NS));
		return (c == 32'h0000_0000) ? 32'h0000_0001 : c;
	endfunction : ns2cyc

	logic [31:0] ctrl_reg, pos_cmd_reg, vel_cmd_reg, max_vel_reg, max_acc_reg;
	logic [31:0] len_reg, spc_reg, setup_reg, hold_reg, inv_scale_reg;
	logic [31:0] table_reg [4];
	logic [31:0] rdata_reg, rdata_next;
	logic [31:0] counts_reg, pos_fb_reg, vel_fb_reg;

	wire logic       en      = ctrl_reg[CTRL_EN_BIT];
	wire logic       vmode   = ctrl_reg[CTRL_VEL_BIT];
	wire logic [7:0] fmt     = ctrl_reg[CTRL_FMT_LSB +: 8];
	wire logic [2:0] wid_raw = ctrl_reg[CTRL_WID_LSB +: 3];

	// register writes; only software writes these
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl_reg      <= CTRL_RST;
			pos_cmd_reg   <= 32'h0000_0000;
			vel_cmd_reg   <= 32'h0000_0000;
			max_vel_reg   <= 32'h0000_0000;
			max_acc_reg   <= MAX_ACC_RST;
			len_reg       <= 32'h0000_0000;
			spc_reg       <= 32'h0000_0000;
			setup_reg     <= 32'h0000_0000;
			hold_reg      <= 32'h0000_0000;
			inv_scale_reg <= INV_SCALE_RST;
			for (int i = 0; i < 4; i++) begin
				table_reg[i] <= 32'h0000_0000;
			end
		end else if (req_in.wr) begin
			case (req_in.addr)
				OFS_CTRL:      ctrl_reg      <= req_in.wdata;
				OFS_POS_CMD:   pos_cmd_reg   <= req_in.wdata;
				OFS_VEL_CMD:   vel_cmd_reg   <= req_in.wdata;
				OFS_MAX_VEL:   max_vel_reg   <= req_in.wdata;
				OFS_MAX_ACC:   max_acc_reg   <= req_in.wdata;
				OFS_STEP_LEN:  len_reg       <= req_in.wdata;
				OFS_STEP_SPC:  spc_reg       <= req_in.wdata;
				OFS_DIR_SETUP: setup_reg     <= req_in.wdata;
				OFS_DIR_HOLD:  hold_reg      <= req_in.wdata;
				OFS_INV_SCALE: inv_scale_reg <= req_in.wdata;
				OFS_TABLE0, OFS_TABLE0 + 8'h04,
				OFS_TABLE0 + 8'h08, OFS_TABLE0 + 8'h0C:
					table_reg[2'((req_in.addr - OFS_TABLE0) >> 2)] <= req_in.wdata;
				default: ;
			endcase
		end
	end

	// read data appear in the cycle after the strobe only
	always_comb begin
		rdata_next = 32'h0000_0000;
		if (req_in.rd) begin
			case (req_in.addr)
				OFS_CTRL:      rdata_next = ctrl_reg;
				OFS_POS_CMD:   rdata_next = pos_cmd_reg;
				OFS_VEL_CMD:   rdata_next = vel_cmd_reg;
				OFS_MAX_VEL:   rdata_next = max_vel_reg;
				OFS_MAX_ACC:   rdata_next = max_acc_reg;
				OFS_STEP_LEN:  rdata_next = len_reg;
				OFS_STEP_SPC:  rdata_next = spc_reg;
				OFS_DIR_SETUP: rdata_next = setup_reg;
				OFS_DIR_HOLD:  rdata_next = hold_reg;
				OFS_INV_SCALE: rdata_next = inv_scale_reg;
				OFS_TABLE0, OFS_TABLE0 + 8'h04,
				OFS_TABLE0 + 8'h08, OFS_TABLE0 + 8'h0C:
					rdata_next = table_reg[2'((req_in.addr - OFS_TABLE0) >> 2)];
				OFS_COUNTS:    rdata_next = counts_reg;
				OFS_POS_FB:    rdata_next = pos_fb_reg;
				OFS_VEL_FB:    rdata_next = vel_fb_reg;
				default:       rdata_next = 32'h0000_0000;
			endcase
		end
	end

	// motion: velocity and fractional position (24 fraction bits)
	logic signed [55:0] acc_reg, acc_next;
	logic signed [31:0] vel_reg, vel_next;
	logic [9:0]         tick_reg, tick_next;
	logic signed [55:0] err;
	logic signed [31:0] want, lim, backlog;
	always_comb begin
		lim  = (max_vel_reg == 32'h0000_0000) ? $signed(VEL_NO_LIMIT)
		                                       : $signed(max_vel_reg);
		err  = $signed({pos_cmd_reg, 16'h0000}) - acc_reg;
		want = vmode ? $signed(vel_cmd_reg) : 32'(err >>> POS_GAIN_SHIFT);
		if (!vmode && ((err >>> POS_GAIN_SHIFT) > 56'(lim))) want = lim;
		if (!vmode && ((err >>> POS_GAIN_SHIFT) < -56'(lim))) want = -lim;
		if (want > lim) want = lim;
		if (want < -lim) want = -lim;
		tick_next = 10'(tick_reg + 10'h001);
		vel_next  = vel_reg;
		if (max_acc_reg == 32'h0000_0000) begin
			vel_next = want;
		end else if (tick_reg == 10'(ACC_TICK_CYC - 1)) begin
			if (want > vel_reg + $signed(max_acc_reg))
				vel_next = vel_reg + $signed(max_acc_reg);
			else if (want < vel_reg - $signed(max_acc_reg))
				vel_next = vel_reg - $signed(max_acc_reg);
			else
				vel_next = want;
		end
		// with no velocity limit set and the step engine behind: hold the integrator so speed
		// settles at what the current step timing really allows
		backlog  = acc_reg[55:24] - $signed(counts_reg);
		acc_next = acc_reg + 56'(vel_reg);
		if (max_vel_reg == 32'h0000_0000 &&
		    (backlog > 32'sd1 || backlog < -32'sd1))
			acc_next = acc_reg;
		if (!en) begin
			vel_next = 32'sh0000_0000;
			acc_next = {$signed(counts_reg), 24'h00_0000};
		end
	end
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			acc_reg  <= 56'sh0;
			vel_reg  <= 32'sh0;
			tick_reg <= 10'h000;
		end else begin
			acc_reg  <= acc_next;
			vel_reg  <= vel_next;
			tick_reg <= tick_next;
		end
	end

	// step engine and pin patterns
	spg_state_t         st_reg, st_next;
	logic [31:0]        tmr_reg, tmr_next, counts_next;
	logic               dir_reg, dir_next, pulse_reg, pulse_next;
	logic [1:0]         qidx_reg, qidx_next, qsub_reg, qsub_next;
	logic [3:0]         tidx_reg, tidx_next;
	logic [PIN_MAX-1:0] pin_reg, pin_next, oe_reg, oe_next;
	logic signed [31:0] diff;
	logic signed [55:0] rnd;
	logic [4:0]         tlen;
	logic [2:0]         wid;
	logic [7:0]         tbyte;
	logic               step_now;
	always_comb begin
		st_next     = st_reg;
		tmr_next    = (tmr_reg != 32'h0000_0000) ? tmr_reg - 32'h0000_0001
		                                         : tmr_reg;
		counts_next = counts_reg;
		dir_next    = dir_reg;
		pulse_next  = pulse_reg;
		qidx_next   = qidx_reg;
		qsub_next   = qsub_reg;
		tidx_next   = tidx_reg;
		step_now    = 1'b0;
		// round to the nearest step: a position move closes on its target
		// exponentially from below, so a floor would stall one step short
		rnd  = acc_reg + 56'sh80_0000;
		diff = rnd[55:24] - $signed(counts_reg);
		tlen = (fmt > 8'h10) ? 5'h10 : 5'(fmt);
		case (st_reg)
			ST_IDLE: begin
				if (en && diff != 32'sh0) begin
					if ((diff < 0) != dir_reg) begin
						dir_next = (diff < 0);
						tmr_next = ns2cyc(setup_reg);
						st_next  = ST_SETUP;
					end else begin
						step_now = 1'b1;
					end
				end
			end
			ST_SETUP: begin
				if (!en) st_next = ST_IDLE;
				else if (tmr_reg <= 32'h0000_0001) step_now = 1'b1;
			end
			ST_PULSE: begin
				if (tmr_reg <= 32'h0000_0001) begin
					if (fmt == FMT_QUAD && qsub_reg != 2'b11) begin
						qsub_next = qsub_reg + 2'b01;
						qidx_next = dir_reg ? qidx_reg - 2'b01
						                    : qidx_reg + 2'b01;
						tmr_next  = ns2cyc(len_reg);
					end else begin
						if (fmt == FMT_QUAD)
							qidx_next = dir_reg ? qidx_reg - 2'b01
							                    : qidx_reg + 2'b01;
						pulse_next = 1'b0;
						// gap covers both spacing and direction hold
						tmr_next = (ns2cyc(spc_reg) > ns2cyc(hold_reg))
						           ? ns2cyc(spc_reg) : ns2cyc(hold_reg);
						st_next  = ST_SPACE;
					end
				end
			end
			ST_SPACE: begin
				if (tmr_reg <= 32'h0000_0001) st_next = ST_IDLE;
			end
			default: st_next = ST_IDLE;
		endcase
		if (step_now) begin
			counts_next = dir_next ? counts_reg - 32'h0000_0001
			                       : counts_reg + 32'h0000_0001;
			pulse_next  = 1'b1;
			qsub_next   = 2'b00;
			tmr_next    = ns2cyc(len_reg);
			st_next     = ST_PULSE;
			if (fmt > FMT_QUAD && tlen != 5'h00) begin
				if (!dir_next)
					tidx_next = (5'(tidx_reg) >= tlen - 5'h01) ? 4'h0
					            : tidx_reg + 4'h1;
				else
					tidx_next = (tidx_reg == 4'h0) ? 4'(tlen - 5'h01)
					            : tidx_reg - 4'h1;
			end
		end
		// pin levels from the next state so outputs stay registered
		tbyte = table_reg[tidx_next[3:2]][8*tidx_next[1:0] +: 8];
		pin_next = '0;
		case (fmt)
			FMT_STEP_DIR: pin_next[1:0] = {dir_next, pulse_next};
			FMT_UP_DOWN:  pin_next[1:0] = {pulse_next & dir_next,
			                               pulse_next & ~dir_next};
			FMT_QUAD:     pin_next[1:0] = {qidx_next[1],
			                               qidx_next[1] ^ qidx_next[0]};
			default:      pin_next = tbyte[PIN_MAX-1:0];
		endcase
		wid = (wid_raw < 3'(PIN_MIN)) ? 3'(PIN_MIN)
		    : (wid_raw > 3'(PIN_MAX)) ? 3'(PIN_MAX) : wid_raw;
		for (int i = 0; i < PIN_MAX; i++) begin
			oe_next[i] = (3'(i) >= wid);
			if (3'(i) >= wid) pin_next[i] = 1'b0;
		end
	end
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_reg     <= ST_IDLE;
			tmr_reg    <= 32'h0000_0000;
			counts_reg <= 32'h0000_0000;
			dir_reg    <= 1'b0;
			pulse_reg  <= 1'b0;
			qidx_reg   <= 2'b00;
			qsub_reg   <= 2'b00;
			tidx_reg   <= 4'h0;
			pin_reg    <= '0;
			oe_reg     <= 6'h3C;
		end else begin
			st_reg     <= st_next;
			tmr_reg    <= tmr_next;
			counts_reg <= counts_next;
			dir_reg    <= dir_next;
			pulse_reg  <= pulse_next;
			qidx_reg   <= qidx_next;
			qsub_reg   <= qsub_next;
			tidx_reg   <= tidx_next;
			pin_reg    <= pin_next;
			oe_reg     <= oe_next;
		end
	end

	// feedback: position scaled every cycle, velocity per sample window
	logic [31:0]        win_reg, win_next, pos_fb_next, vel_fb_next;
	logic signed [31:0] wsteps_reg, wsteps_next;
	logic signed [88:0] pprod;
	logic signed [63:0] vprod;
	always_comb begin
		pprod       = acc_reg * $signed({1'b0, inv_scale_reg});
		pos_fb_next = pprod[55:24];
		win_next    = win_reg + 32'h0000_0001;
		wsteps_next = wsteps_reg + 32'(counts_next - counts_reg);
		vprod       = 64'(wsteps_reg) * 64'(FB_WINDOW_HZ)
		            * $signed({32'h0, inv_scale_reg});
		vel_fb_next = vel_fb_reg;
		if (win_reg == 32'(FB_WINDOW_CYC - 1)) begin
			win_next    = 32'h0000_0000;
			wsteps_next = 32'(counts_next - counts_reg);
			vel_fb_next = vprod[31:0];
		end
		if (!en) vel_fb_next = 32'h0000_0000;
	end
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			win_reg    <= 32'h0000_0000;
			wsteps_reg <= 32'sh0;
			pos_fb_reg <= 32'h0000_0000;
			vel_fb_reg <= 32'h0000_0000;
			rdata_reg  <= 32'h0000_0000;
		end else begin
			win_reg    <= win_next;
			wsteps_reg <= wsteps_next;
			pos_fb_reg <= pos_fb_next;
			vel_fb_reg <= vel_fb_next;
			rdata_reg  <= rdata_next;
		end
	end

	assign rdata_out    = rdata_reg;
	assign pin_out      = pin_reg;
	assign pin_oe_n_out = oe_reg;
endmodule : spg_step_gen

// File: src/spg_pkg.sv
// Purpose: constants and types shared by the step pulse generator
// Assumes: 50 MHz system clock, 32-bit register port
// Notes:   fixed-point formats are listed beside each register offset
package spg_pkg;
	localparam int          CLK_PERIOD_NS = 20;
	localparam int          FB_WINDOW_HZ  = 1000; // velocity sample rate
	localparam int          FB_WINDOW_CYC = 50000000 / FB_WINDOW_HZ;
	localparam int          ACC_TICK_CYC  = 1024; // accel applied per tick
	localparam int          POS_GAIN_SHIFT = 10;  // position loop gain
	// register offsets (byte addresses)
	localparam logic [7:0]  OFS_CTRL      = 8'h00; // [0]en [1]vel [15:8]fmt
	localparam logic [7:0]  OFS_POS_CMD   = 8'h04; // steps, 8 frac bits
	localparam logic [7:0]  OFS_VEL_CMD   = 8'h08; // steps/clk, 24 frac
	localparam logic [7:0]  OFS_MAX_VEL   = 8'h0C; // steps/clk, 24 frac
	localparam logic [7:0]  OFS_MAX_ACC   = 8'h10; // per tick, 24 frac
	localparam logic [7:0]  OFS_STEP_LEN  = 8'h14; // ns
	localparam logic [7:0]  OFS_STEP_SPC  = 8'h18; // ns
	localparam logic [7:0]  OFS_DIR_SETUP = 8'h1C; // ns
	localparam logic [7:0]  OFS_DIR_HOLD  = 8'h20; // ns
	localparam logic [7:0]  OFS_INV_SCALE = 8'h24; // user units/step, 16 frac
	localparam logic [7:0]  OFS_TABLE0    = 8'h28; // 0x28..0x34
	localparam logic [7:0]  OFS_COUNTS    = 8'h38; // read only
	localparam logic [7:0]  OFS_POS_FB    = 8'h3C; // read only, 16 frac
	localparam logic [7:0]  OFS_VEL_FB    = 8'h40; // read only, 16 frac
	// control field positions
	localparam int          CTRL_EN_BIT   = 0;
	localparam int          CTRL_VEL_BIT  = 1;
	localparam int          CTRL_FMT_LSB  = 8;
	localparam int          CTRL_WID_LSB  = 16;
	// values after reset
	localparam logic [31:0] CTRL_RST      = 32'h0002_0000; // width 2, pos
	localparam logic [31:0] MAX_ACC_RST   = 32'h0000_0001;
	localparam logic [31:0] INV_SCALE_RST = 32'h0001_0000;
	localparam logic [31:0] VEL_NO_LIMIT  = 32'h7FFF_FFFF;
	localparam logic [7:0]  FMT_STEP_DIR  = 8'h00;
	localparam logic [7:0]  FMT_UP_DOWN   = 8'h01;
	localparam logic [7:0]  FMT_QUAD      = 8'h02;
	localparam int          PIN_MAX       = 6;
	localparam int          PIN_MIN       = 2;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} spg_req_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_SETUP = 2'b01,
		ST_PULSE = 2'b10,
		ST_SPACE = 2'b11
	} spg_state_t;
endpackage : spg_pkg

// File: tb/spg_step_gen_monitor.sv
// Purpose: port-level checker for the step pulse generator
// Assumes: config shadowed from write strobes on the register port
// Notes:   format checks wait for a settled control word
`timescale 1ns/1ns
module spg_step_gen_monitor
	import spg_pkg::*;
(
	input  wire logic               sys_clk_in,
	input  wire logic               rst_n_in,
	input  wire spg_req_t           req_in,
	input  wire logic [31:0]        rdata_out,
	input  wire logic [PIN_MAX-1:0] pin_out,
	input  wire logic [PIN_MAX-1:0] pin_oe_n_out
);
	logic [31:0] ctrl_reg;
	logic [15:0] len_reg, spc_reg, set_reg, hld_reg, hi_reg, lo_reg, dir_reg;
	logic [3:0]  age_reg;
	logic        d1_reg;
	logic [2:0]  wid;
	logic        sd;
	function automatic logic [15:0] cyc(input logic [31:0] ns);
		return (ns == 32'h0) ? 16'h1 : 16'((ns + 32'h13) / 32'h14);
	endfunction : cyc
	// width clamp as the design applies it
	assign wid = (ctrl_reg[18:16] < 3'h2) ? 3'h2 :
		(ctrl_reg[18:16] > 3'h6) ? 3'h6 : ctrl_reg[18:16];
	assign sd = (age_reg > 4'h2) && (ctrl_reg[15:8] == FMT_STEP_DIR);
	// counters other than hi_reg saturate so a long idle never wraps into a false failure
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl_reg <= CTRL_RST;
			{len_reg, spc_reg, set_reg, hld_reg} <= {4{16'h1}};
			{hi_reg, lo_reg, dir_reg} <= {16'h0, 16'hFFFF, 16'hFFFF};
			age_reg <= 4'h0;
			d1_reg <= 1'b0;
		end else begin
			age_reg <= age_reg + 4'(age_reg != 4'hF);
			hi_reg <= pin_out[0] ? hi_reg + 16'h1 : 16'h0;
			lo_reg <= pin_out[0] ? 16'h0 : lo_reg + 16'(lo_reg != 16'hFFFF);
			d1_reg <= pin_out[1];
			dir_reg <= (pin_out[1] != d1_reg) ? 16'h1 :
				dir_reg + 16'(dir_reg != 16'hFFFF);
			if (req_in.wr) begin
				case (req_in.addr)
					OFS_CTRL: begin
						ctrl_reg <= req_in.wdata;
						age_reg <= 4'h0;
					end
					OFS_STEP_LEN:  len_reg <= cyc(req_in.wdata);
					OFS_STEP_SPC:  spc_reg <= cyc(req_in.wdata);
					OFS_DIR_SETUP: set_reg <= cyc(req_in.wdata);
					OFS_DIR_HOLD:  hld_reg <= cyc(req_in.wdata);
					default: ;
				endcase
			end
		end
	end
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_rise;
		$rose(pin_out[0]);
	endsequence
	sequence s_fall;
		$fell(pin_out[0]);
	endsequence
	a_pulse_len: assert property (sd ##0 s_fall |-> hi_reg == len_reg)
		else $error("step pulse length wrong");
	a_step_space: assert property (sd ##0 s_rise |->
		lo_reg >= spc_reg && lo_reg >= hld_reg) else $error("step gap short");
	a_dir_setup: assert property (sd ##0 s_rise |-> dir_reg >= set_reg)
		else $error("direction setup short");
	a_dir_hold: assert property (sd && pin_out[1] != d1_reg |->
		lo_reg >= hld_reg) else $error("direction hold short");
	a_no_step_off: assert property (age_reg > 4'h2 &&
		!ctrl_reg[CTRL_EN_BIT] |-> !$rose(pin_out[0]))
		else $error("step while disabled");
	a_updown_excl: assert property (age_reg > 4'h2 &&
		ctrl_reg[15:8] == FMT_UP_DOWN |-> !(pin_out[0] && pin_out[1]))
		else $error("up and down both active");
	a_quad_gray: assert property (age_reg > 4'h2 &&
		ctrl_reg[15:8] == FMT_QUAD && pin_out[1:0] != $past(pin_out[1:0])
		|-> $countones(pin_out[1:0] ^ $past(pin_out[1:0])) == 1)
		else $error("quadrature not gray");
	a_released_low: assert property ((pin_out & pin_oe_n_out) == 6'h00)
		else $error("released pin driven high");
	a_width_oe: assert property (age_reg > 4'h2 |->
		pin_oe_n_out == 6'(6'h3F << wid)) else $error("pin enables wrong");
endmodule : spg_step_gen_monitor
bind spg_step_gen spg_step_gen_monitor u_mon (.sys_clk_in(sys_clk_in),
	.rst_n_in(rst_n_in), .req_in(req_in), .rdata_out(rdata_out),
	.pin_out(pin_out), .pin_oe_n_out(pin_oe_n_out));

// File: tb/spg_drv_model.sv
// Purpose: motor driver model that decodes steps from the pins
// Assumes: bench tells it the format in use
// Notes:   a format switch may glitch the count, so callers take deltas
`timescale 1ns/1ns
module spg_drv_model
	import spg_pkg::*;
(
	input  wire logic               clk_in,
	input  wire logic [7:0]         fmt_in,
	input  wire logic [PIN_MAX-1:0] pin_in,
	input  wire logic [PIN_MAX-1:0] oe_n_in,
	output int                      steps_out
);
	logic [PIN_MAX-1:0] lvl, prv;
	logic [1:0]         ix, pix;
	int                 qtr;
	// released pins float high through the pull-up
	assign lvl = pin_in | oe_n_in;
	assign ix = {lvl[1], lvl[1] ^ lvl[0]};
	assign pix = {prv[1], prv[1] ^ prv[0]};
	initial begin
		steps_out = 0;
		qtr = 0;
		prv = '0;
	end
	// one decoder per pin format, none for tables; quadrature counts quarters, four to a step
	always @(posedge clk_in) begin
		prv <= lvl;
		case (fmt_in)
			FMT_STEP_DIR: if (lvl[0] && !prv[0])
				steps_out <= steps_out + (lvl[1] ? -1 : 1);
			FMT_UP_DOWN: steps_out <= steps_out +
				int'(lvl[0] && !prv[0]) - int'(lvl[1] && !prv[1]);
			FMT_QUAD: begin
				if (ix == pix + 2'h1) qtr = qtr + 1;
				else if (ix == pix - 2'h1) qtr = qtr - 1;
				steps_out <= qtr / 4;
			end
			default: ;
		endcase
	end
endmodule : spg_drv_model

// File: tb/step_pulse_generator_test.sv
// Purpose: self-checking bench for the step pulse generator
// Assumes: timing 40/40/60/20 ns, so one step every 5 clocks at best
// Notes:   velocity feedback gets only a loose bound, window phase unknown
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module step_pulse_generator_test
	import spg_pkg::*;
;
	localparam int      PER = 5; // len 2 + max(space 2, hold 1) + idle 1
	localparam int      VFB = 50000000 / PER * 16 / 100; // 1% of full rate
	logic               sys_clk_in = 1'b0;
	logic               rst_n_in   = 1'b0;
	spg_req_t           req_in     = '0;
	logic [31:0]        rdata_out, d, a, c0;
	logic [PIN_MAX-1:0] pin_out, pin_oe_n_out;
	logic [7:0]         fmt        = FMT_STEP_DIR;
	logic [7:0]         tbl[$]     = '{8'h01, 8'h22, 8'h13, 8'h3C};
	logic [7:0]         ra[8]      = '{OFS_CTRL, OFS_MAX_ACC, OFS_INV_SCALE,
		OFS_MAX_VEL, OFS_STEP_LEN, OFS_COUNTS, OFS_VEL_FB, 8'hFC};
	logic [31:0]        rv[8]      = '{CTRL_RST, MAX_ACC_RST, INV_SCALE_RST,
		32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
	logic [7:0]         fq[2]      = '{FMT_UP_DOWN, FMT_QUAD};
	logic [2:0]         wa[3]      = '{3'h3, 3'h7, 3'h1};
	logic [5:0]         wo[3]      = '{6'h38, 6'h00, 6'h3C};
	int                 steps, base, k, t, exp_cnt = 0;
	int                 err_count = 0, n_checks = 0;
	always #10 sys_clk_in = ~sys_clk_in;
	spg_step_gen dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
		.req_in(req_in), .rdata_out(rdata_out), .pin_out(pin_out),
		.pin_oe_n_out(pin_oe_n_out));
	spg_drv_model u_drv (.clk_in(sys_clk_in), .fmt_in(fmt), .pin_in(pin_out),
		.oe_n_in(pin_oe_n_out), .steps_out(steps));
	// register port cycles, strobes one clock long
	task wr(input logic [7:0] ad, input logic [31:0] v);
		@(posedge sys_clk_in) req_in <= '{ad, v, 1'b1, 1'b0};
		@(posedge sys_clk_in) req_in <= '0;
	endtask : wr
	task rd(input logic [7:0] ad, output logic [31:0] v);
		@(posedge sys_clk_in) req_in <= '{ad, 32'h0, 1'b0, 1'b1};
		@(posedge sys_clk_in) req_in <= '0;
		#1 v = rdata_out;
	endtask : rd
	task ctl(input logic en, input logic vel, input logic [7:0] f,
		input logic [2:0] w);
		fmt <= f;
		wr(OFS_CTRL, {13'h0, w, f, 6'h0, vel, en});
		repeat (4) @(posedge sys_clk_in);
	endtask : ctl
	// position move; a target never reached ends the run
	task go(input int tgt);
		exp_cnt = tgt;
		wr(OFS_POS_CMD, 32'(tgt) << 8);
		for (int i = 0; i < 3000; i++) begin
			rd(OFS_COUNTS, d);
			if (d === 32'(tgt)) break;
		end
		`CHK(d, 32'(exp_cnt))
		if (d !== 32'(tgt)) wrap_up();
		repeat (12) @(posedge sys_clk_in);
	endtask : go
	task wrap_up;
		$display("checks=%0d mismatches=%0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up
	initial begin
		d = $urandom(83244);
		repeat (2) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		// reset values, read-only write ignored, unmapped reads zero
		wr(OFS_COUNTS, 32'h0000_0055);
		foreach (ra[i]) begin
			rd(ra[i], d);
			`CHK(d, rv[i])
		end
		`CHK(pin_oe_n_out, 6'h3C)
		$display("test reset done");
		wr(OFS_STEP_LEN, 32'h28);
		wr(OFS_STEP_SPC, 32'h28);
		wr(OFS_DIR_SETUP, 32'h3C);
		wr(OFS_DIR_HOLD, 32'h14);
		wr(OFS_MAX_ACC, 32'h0);
		wr(OFS_INV_SCALE, 32'h8000);
		ctl(1'b1, 1'b0, FMT_STEP_DIR, 3'h2);
		t = 5 + $urandom % 20;
		go(t);
		rd(OFS_POS_FB, d);
		// internal position lands within half a step of the count
		k = $signed(d) - t * 32768;
		`CHK(k >= -16384 && k < 16384, 1'b1)
		`CHK(steps, exp_cnt)
		go(-3);
		`CHK(steps, exp_cnt)
		$display("test position done");
		foreach (fq[i]) begin
			ctl(1'b1, 1'b0, fq[i], 3'h2);
			base = steps;
			go(exp_cnt + 2);
			`CHK(steps - base, 2)
			go(exp_cnt - 2);
			`CHK(steps - base, 0)
		end
		// table of four phases, each step must show the next byte
		wr(OFS_TABLE0, 32'h3C13_2201);
		ctl(1'b1, 1'b0, 8'h04, 3'h6);
		`CHK(pin_oe_n_out, 6'h00)
		for (int j = 0; j < 5; j++) begin
			k = -1;
			foreach (tbl[m]) if (tbl[m] === {2'h0, pin_out}) k = m;
			go(exp_cnt + 1);
			`CHK({2'h0, pin_out}, tbl[(k + 1) % 4])
		end
		foreach (wa[i]) begin
			ctl(1'b0, 1'b0, FMT_STEP_DIR, wa[i]);
			`CHK(pin_oe_n_out, wo[i])
		end
		$display("test formats done");
		base = steps;
		rd(OFS_COUNTS, c0);
		wr(OFS_INV_SCALE, 32'h10);
		wr(OFS_VEL_CMD, 32'h0100_0000);
		wr(OFS_MAX_ACC, 32'h0001_0000);
		ctl(1'b1, 1'b1, FMT_STEP_DIR, 3'h2);
		rd(OFS_COUNTS, a);
		repeat (1000) @(posedge sys_clk_in);
		rd(OFS_COUNTS, d);
		`CHK(d - a < 32'h14, 1'b1)
		ctl(1'b0, 1'b1, FMT_STEP_DIR, 3'h2);
		rd(OFS_VEL_FB, d);
		`CHK(d, 32'h0)
		rd(OFS_COUNTS, a);
		repeat (100) @(posedge sys_clk_in);
		rd(OFS_COUNTS, d);
		`CHK(d, a)
		// no acceleration limit: rate set only by the step timing
		wr(OFS_MAX_ACC, 32'h0);
		ctl(1'b1, 1'b1, FMT_STEP_DIR, 3'h2);
		rd(OFS_COUNTS, a);
		repeat (1000) @(posedge sys_clk_in);
		rd(OFS_COUNTS, d);
		`CHK(int'(d - a) >= 1000 / PER - 1 && int'(d - a) <= 1004 / PER + 1, 1'b1)
		repeat (55000) @(posedge sys_clk_in);
		rd(OFS_VEL_FB, d);
		// the last window may start before enable: only about an eighth
		// of it is sure to run at the full step rate
		k = int'(d);
		`CHK(k >= VFB * 11 && k <= VFB * 101, 1'b1)
		ctl(1'b0, 1'b1, FMT_STEP_DIR, 3'h2);
		repeat (12) @(posedge sys_clk_in);
		rd(OFS_COUNTS, d);
		`CHK(steps - base, int'(d) - int'(c0))
		$display("test velocity done");
		wrap_up();
	end
endmodule : step_pulse_generator_test
